// >>> hw/mcss_pkg.sv
// Constants and types for the main contactor start/stop sequencer.
// Assumes a single 40 MHz pclk and an APB slave built into the top module.
//
// Overview of operation
// - Start runs the motor only with run enable high and inch low.
// - Start low ramps speed demand to zero at the stop ramp rate.
// - After a ramped stop the contactor opens at zero speed.
// - Coast stop low holds the contactor open and inhibits operation.
// - Coast stop falling while running opens contactor within 100 ms.
// - Coast stop high permits normal operation under other interlocks.
// - No start while any alarm is active.
// - After alarm drop-out, start must be off 50 ms then reapplied.
// - Run enable low during a stop opens the contactor at once.
// - Inch held with start low turns slowly; release ramps at inch rate.
package mcss_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 40000000;
  localparam int unsigned COAST_STOP_INPUT_MS = 100;
  localparam int unsigned START_OFF_MS = 50;
  localparam int unsigned COAST_STOP_INPUT_SETUP_MS = 50;
  // Coast stop opens the contactor three cycles after it falls; 100 ms is far above that
  localparam int unsigned COAST_STOP_INPUT_MAX_CYC = CLK_HZ / 1000 * COAST_STOP_INPUT_MS;
  localparam int unsigned START_OFF_CYC = CLK_HZ / 1000 * START_OFF_MS;
  localparam int unsigned COAST_STOP_INPUT_SETUP_CYC = CLK_HZ / 1000 * COAST_STOP_INPUT_SETUP_MS;

  // ==========================================================================
  // Speed demand
  localparam int SPD_W = 16;
  localparam logic [15:0] SPD_RUN_RST = 16'hffff;
  localparam logic [15:0] SPD_INCH_RST = 16'h0800;
  localparam logic [15:0] STOP_STEP_RST = 16'h0001;
  localparam logic [15:0] INCH_STEP_RST = 16'h0001;
  localparam logic [15:0] ACC_STEP_RST = 16'h0001;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STATUS = 12'h004;
  localparam logic [11:0] OFS_RUN_SPD = 12'h008;
  localparam logic [11:0] OFS_INCH_SPD = 12'h00c;
  localparam logic [11:0] OFS_STOP_STEP = 12'h010;
  localparam logic [11:0] OFS_INCH_STEP = 12'h014;
  localparam logic [11:0] OFS_ACC_STEP = 12'h018;
  localparam logic [11:0] OFS_DEMAND = 12'h01c;

  // Control register fields
  localparam int CTRL_ALARM_BIT = 0;
  localparam int CTRL_ACK_BIT = 1;

  // Status register fields
  localparam int ST_CONT_BIT = 0;
  localparam int ST_LOCK_BIT = 1;
  localparam int ST_STATE_LSB = 4;

  // Sequencer states
  typedef enum logic [2:0] {
    MCSS_IDLE, MCSS_RUN, MCSS_INCH, MCSS_STOP, MCSS_INCH_STOP
  } mcss_state_e;

endpackage

// >>> hw/mcss_sync.sv
// Two-flip-flop synchroniser for a group of input levels.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/10ps
module mcss_sync #(
  parameter int W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  logic [W-1:0] meta_reg;

  // ==========================================================================
  // Two stages; first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// >>> hw/mcss_top.sv
// Main contactor start/stop sequencer with APB register access.
// Assumes switch inputs are asynchronous; zero-speed and alarm inputs
// come from logic on pclk.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/10ps
module mcss_top
  import mcss_pkg::*;
#(
  parameter int unsigned OFF_CYC = START_OFF_CYC,
  parameter int unsigned SETUP_CYC = COAST_STOP_INPUT_SETUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_in,
  input wire logic run_enable_in,
  input wire logic inch_in,
  input wire logic coast_stop_input,
  input wire logic alarm_in,
  input wire logic zero_speed_in,
  output logic contactor_out,
  output logic drive_run,
  output logic [15:0] speed_demand
);

  logic start_s, run_s, inch_s, coast_stop_input_s;
  logic [3:0] sync_q;
  mcss_state_e state_reg, state_next;
  logic [15:0] run_spd_reg, inch_spd_reg;
  logic [15:0] stop_step_reg, inch_step_reg, acc_step_reg;
  logic sw_alarm_reg, lock_reg, start_d_reg;
  logic [31:0] off_cnt_reg, cst_cnt_reg;
  logic off_done, cst_ok, alarm, may_start, wr_en, rd_en;
  logic [15:0] target;

  // ==========================================================================
  // Input synchronisers
  mcss_sync #(.W(4)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({start_in, run_enable_in, inch_in, coast_stop_input}),
    .sync_out(sync_q)
  );
  assign {start_s, run_s, inch_s, coast_stop_input_s} = sync_q;

  // ==========================================================================
  // Interlock timers
  // Time start has been low, saturating
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      off_cnt_reg <= '0;
    end else if (start_s) begin
      off_cnt_reg <= '0;
    end else if (!off_done) begin
      off_cnt_reg <= off_cnt_reg + 32'h1;
    end
  end
  assign off_done = (off_cnt_reg >= OFF_CYC);

  // Time coast stop has been high, saturating; guards against a start
  // that came too soon after coast stop rose
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cst_cnt_reg <= '0;
    end else if (!coast_stop_input_s) begin
      cst_cnt_reg <= '0;
    end else if (!cst_ok) begin
      cst_cnt_reg <= cst_cnt_reg + 32'h1;
    end
  end
  assign cst_ok = (cst_cnt_reg >= SETUP_CYC);

  assign alarm = alarm_in | sw_alarm_reg;

  // Restart lockout after alarm drop-out
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_reg <= 1'b0;
    end else if (alarm && state_reg != MCSS_IDLE) begin
      lock_reg <= 1'b1; // Set wins over release
    end else if (lock_reg && off_done) begin
      lock_reg <= 1'b0;
    end
  end

  // Start edge: start must be reapplied, not merely held
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_d_reg <= 1'b0;
    end else begin
      start_d_reg <= start_s;
    end
  end

  assign may_start = coast_stop_input_s && cst_ok && run_s && !alarm
                     && !lock_reg;

  // ==========================================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      MCSS_IDLE: begin
        if (may_start && start_s && !inch_s && !start_d_reg) begin
          state_next = MCSS_RUN;
        end else if (may_start && inch_s && !start_s) begin
          state_next = MCSS_INCH;
        end
      end
      MCSS_RUN: begin
        if (!start_s || !run_s || inch_s) begin
          state_next = MCSS_STOP;
        end
      end
      MCSS_INCH: begin
        if (!inch_s || start_s || !run_s) begin
          state_next = MCSS_INCH_STOP;
        end
      end
      MCSS_STOP, MCSS_INCH_STOP: begin
        if (speed_demand == 16'h0000 && zero_speed_in) begin
          state_next = MCSS_IDLE;
        end
      end
    endcase
    // Coast stop, alarm or run enable loss drop out at once
    if (!coast_stop_input_s || alarm || (!run_s && state_reg != MCSS_IDLE)) begin
      state_next = MCSS_IDLE;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= MCSS_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================================
  // Speed demand ramp
  always_comb begin
    unique case (state_reg)
      MCSS_RUN: target = run_spd_reg;
      MCSS_INCH: target = inch_spd_reg;
      default: target = 16'h0000;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      speed_demand <= '0;
    end else if (state_next == MCSS_IDLE) begin
      speed_demand <= '0; // Coast: demand removed with no ramp
    end else if (speed_demand < target) begin
      if (target - speed_demand > acc_step_reg) begin
        speed_demand <= speed_demand + acc_step_reg;
      end else begin
        speed_demand <= target;
      end
    end else if (speed_demand > target) begin
      if (state_reg == MCSS_INCH_STOP) begin
        if (speed_demand - target > inch_step_reg) begin
          speed_demand <= speed_demand - inch_step_reg;
        end else begin
          speed_demand <= target;
        end
      end else if (speed_demand - target > stop_step_reg) begin
        speed_demand <= speed_demand - stop_step_reg;
      end else begin
        speed_demand <= target;
      end
    end
  end

  // Contactor and run flag follow the sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contactor_out <= 1'b0;
      drive_run <= 1'b0;
    end else begin
      contactor_out <= (state_next != MCSS_IDLE);
      drive_run <= (state_next == MCSS_RUN || state_next == MCSS_INCH);
    end
  end

  // ==========================================================================
  // APB slave, zero wait states
  assign pready = 1'b1;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign pslverr = psel && penable && (paddr > OFS_DEMAND || paddr[1:0] != 2'b00);

  // Writable registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sw_alarm_reg <= 1'b0;
      run_spd_reg <= SPD_RUN_RST;
      inch_spd_reg <= SPD_INCH_RST;
      stop_step_reg <= STOP_STEP_RST;
      inch_step_reg <= INCH_STEP_RST;
      acc_step_reg <= ACC_STEP_RST;
    end else if (wr_en) begin
      unique case (paddr)
        OFS_CTRL: sw_alarm_reg <= pwdata[CTRL_ALARM_BIT];
        OFS_RUN_SPD: run_spd_reg <= pwdata[15:0];
        OFS_INCH_SPD: inch_spd_reg <= pwdata[15:0];
        OFS_STOP_STEP: stop_step_reg <= pwdata[15:0];
        OFS_INCH_STEP: inch_step_reg <= pwdata[15:0];
        OFS_ACC_STEP: acc_step_reg <= pwdata[15:0];
        default: ;
      endcase
    end
  end

  // Read data captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (rd_en) begin
      unique case (paddr)
        OFS_CTRL: prdata <= {31'h0, sw_alarm_reg};
        OFS_STATUS: prdata <= {25'h0, 3'(state_reg), 2'h0,
                               lock_reg, contactor_out};
        OFS_RUN_SPD: prdata <= {16'h0, run_spd_reg};
        OFS_INCH_SPD: prdata <= {16'h0, inch_spd_reg};
        OFS_STOP_STEP: prdata <= {16'h0, stop_step_reg};
        OFS_INCH_STEP: prdata <= {16'h0, inch_step_reg};
        OFS_ACC_STEP: prdata <= {16'h0, acc_step_reg};
        OFS_DEMAND: prdata <= {16'h0, speed_demand};
        default: prdata <= '0;
      endcase
    end
  end

endmodule

// >>> testbench/mcss_props.sv
// Checker of the sequencer's port behaviour.
// Assumes it is bound into mcss_top and sees only its ports.
`timescale 1ns/10ps
module mcss_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [11:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start_in,
  input wire logic run_enable_in,
  input wire logic inch_in,
  input wire logic coast_stop_input,
  input wire logic alarm_in,
  input wire logic contactor_out,
  input wire logic drive_run,
  input wire logic [15:0] speed_demand
);
  // ==========================================================================
  // Contactor interlocks, stop ramp and bus errors
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_coast_hold: assert property (
    !coast_stop_input [*6] |-> !contactor_out) else $error("coast hold");
  chk_coast_fast: assert property (
    $fell(coast_stop_input) && contactor_out |->
    ##[1:8] (!contactor_out && speed_demand == 16'h0000))
    else $error("coast drop");
  chk_run_drop: assert property (
    !run_enable_in [*6] |-> !contactor_out) else $error("run drop");
  chk_alarm_drop: assert property (
    alarm_in [*4] |-> !contactor_out) else $error("alarm drop");
  chk_start_cause: assert property (
    $rose(contactor_out) |-> $past(start_in, 2) != $past(inch_in, 2))
    else $error("start cause");
  chk_stop_ramp: assert property (
    contactor_out && !drive_run && !$past(drive_run) &&
    $past(speed_demand) != 16'h0000 |-> speed_demand < $past(speed_demand))
    else $error("stop ramp");
  chk_zero_drop: assert property (
    $fell(contactor_out) && !$past(drive_run) && run_enable_in &&
    coast_stop_input && !alarm_in |-> $past(speed_demand) == 16'h0000)
    else $error("zero drop");
  chk_bad_addr: assert property (
    psel && penable && paddr > 12'h01c |-> pslverr && pready)
    else $error("bad address");
  cover property ($rose(contactor_out));
  cover property ($fell(coast_stop_input) && contactor_out);
  cover property (psel && penable && pslverr);
endmodule
bind mcss_top mcss_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .paddr(paddr), .pready(pready),
  .pslverr(pslverr), .start_in(start_in), .run_enable_in(run_enable_in),
  .inch_in(inch_in), .coast_stop_input(coast_stop_input),
  .alarm_in(alarm_in), .contactor_out(contactor_out),
  .drive_run(drive_run), .speed_demand(speed_demand));

// >>> testbench/mcss_switches.sv
// Model of the operator switches and the motor at the sequencer inputs.
// Assumes bench commands on pclk; the motor stops when demand is zero.
`timescale 1ns/10ps
module mcss_switches
  import mcss_pkg::*;
#(
  parameter int unsigned SETUP_CYC = COAST_STOP_INPUT_SETUP_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic want_start,
  input wire logic want_run,
  input wire logic want_inch,
  input wire logic want_coast,
  input wire logic [15:0] speed_demand,
  output logic start_in,
  output logic run_enable_in,
  output logic inch_in,
  output logic coast_stop_input,
  output logic zero_speed_in
);
  // ==========================================================================
  // Coast stop settling; margin covers the sequencer's synchroniser
  logic [21:0] settle_reg;
  logic settled;
  assign settled = settle_reg >= 22'(SETUP_CYC + 8);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      settle_reg <= '0;
    end else if (!coast_stop_input) begin
      settle_reg <= '0;
    end else if (!settled) begin
      settle_reg <= settle_reg + 22'h000001;
    end
  end
  // Switch levels and motor zero speed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_in <= 1'b0;
      run_enable_in <= 1'b0;
      inch_in <= 1'b0;
      coast_stop_input <= 1'b0;
      zero_speed_in <= 1'b1;
    end else begin
      start_in <= want_start && settled;
      run_enable_in <= want_run;
      inch_in <= want_inch;
      coast_stop_input <= want_coast;
      zero_speed_in <= speed_demand == 16'h0000;
    end
  end
endmodule

// >>> testbench/tb.sv
// Self-checking bench for the contactor sequencer.
// Assumes mcss_top, the switch model and the bound checker.
`timescale 1ns/10ps
module tb
  import mcss_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, er, zero_speed_in, contactor_out, drive_run;
  logic start_in, run_enable_in, inch_in, coast_stop_input;
  logic alarm_in = 1'b0;
  logic w_start = 1'b0;
  logic w_run = 1'b1;
  logic w_inch = 1'b0;
  logic w_coast = 1'b0;
  logic [15:0] speed_demand, dm;
  int n_mismatch = 0;
  int total_checks = 0;
  // One millisecond counts as 40 cycles here so the run stays short
  localparam int unsigned T_SETUP = 40 * COAST_STOP_INPUT_SETUP_MS;
  localparam int unsigned T_OFF = 40 * START_OFF_MS;
  // Rows: run enable, inch, alarm, expected run flag
  logic [3:0] rows [4] = '{4'h9, 4'h0, 4'hc, 4'ha};
  always #12.5 pclk = ~pclk;
  mcss_top #(.OFF_CYC(T_OFF), .SETUP_CYC(T_SETUP)) dut (.pclk(pclk),
    .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .start_in(start_in), .run_enable_in(run_enable_in), .inch_in(inch_in),
    .coast_stop_input(coast_stop_input), .alarm_in(alarm_in),
    .zero_speed_in(zero_speed_in), .contactor_out(contactor_out),
    .drive_run(drive_run), .speed_demand(speed_demand));
  mcss_switches #(.SETUP_CYC(T_SETUP)) u_sw (.pclk(pclk),
    .presetn(presetn), .want_start(w_start),
    .want_run(w_run), .want_inch(w_inch), .want_coast(w_coast),
    .speed_demand(speed_demand), .start_in(start_in),
    .run_enable_in(run_enable_in), .inch_in(inch_in),
    .coast_stop_input(coast_stop_input), .zero_speed_in(zero_speed_in));
  // ==========================================================================
  // Checking and bus tasks
  task automatic results;
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic wait_cont(input logic lv, input int n);
    for (int i = 0; i < n && contactor_out !== lv; i++) @(negedge pclk);
    if (contactor_out !== lv) begin
      n_mismatch++;
      $display("[ERR] %0t contactor wait timed out", $time);
      results();
    end
    tick(1);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Access phase lasts until pready is seen high, bounded
    for (int i = 0; i < 16 && pready !== 1'b1; i++) @(posedge pclk);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t bus wait timed out", $time);
      results();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    tick(16);
    presetn <= 1'b1;
    @(negedge pclk);
    cmp(32'({contactor_out, drive_run, speed_demand}), 32'h0);
    apb(1'b0, OFS_RUN_SPD, 32'h0);
    cmp(rd, 32'h0000ffff);
    apb(1'b0, 12'h020, 32'h0);
    cmp({rd[30:0], er}, 32'h1);
    apb(1'b1, OFS_STOP_STEP, 32'h2);
    w_coast <= 1'b1;
    tick(T_SETUP + 16);
    foreach (rows[k]) begin
      w_run <= rows[k][3];
      w_inch <= rows[k][2];
      alarm_in <= rows[k][1];
      tick(4);
      w_start <= 1'b1;
      tick(10);
      cmp(32'(drive_run), 32'(rows[k][0]));
      w_start <= 1'b0;
      w_inch <= 1'b0;
      alarm_in <= 1'b0;
      w_run <= 1'b1;
      wait_cont(1'b0, 400);
    end
    // Ramped stop at the programmed step, contactor opens at zero
    w_start <= 1'b1;
    tick(40);
    w_start <= 1'b0;
    tick(8);
    @(negedge pclk);
    dm = speed_demand;
    @(negedge pclk);
    cmp(32'(speed_demand), 32'(dm - 16'h0002));
    cmp(32'(contactor_out), 32'h1);
    wait_cont(1'b0, 200);
    cmp(32'(speed_demand), 32'h0);
    // Run enable removed in mid-ramp, then an inch run and its release
    w_start <= 1'b1;
    tick(40);
    w_start <= 1'b0;
    tick(6);
    w_run <= 1'b0;
    wait_cont(1'b0, 6);
    w_run <= 1'b1;
    tick(4);
    w_inch <= 1'b1;
    tick(20);
    cmp(32'({contactor_out, drive_run}), 32'h3);
    w_inch <= 1'b0;
    wait_cont(1'b0, 400);
    // Alarm drop-out, lockout, restart after start held off
    w_start <= 1'b1;
    tick(10);
    alarm_in <= 1'b1;
    wait_cont(1'b0, 4);
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp(32'(rd[ST_LOCK_BIT]), 32'h1);
    alarm_in <= 1'b0;
    w_start <= 1'b0;
    tick(20);
    w_start <= 1'b1;
    tick(20);
    cmp(32'(contactor_out), 32'h0);
    w_start <= 1'b0;
    tick(T_OFF + 16);
    w_start <= 1'b1;
    wait_cont(1'b1, 10);
    // Software alarm drops a running drive and also locks out restart
    apb(1'b1, OFS_CTRL, 32'h1);
    wait_cont(1'b0, 4);
    apb(1'b0, OFS_STATUS, 32'h0);
    cmp(32'(rd[ST_LOCK_BIT]), 32'h1);
    apb(1'b1, OFS_CTRL, 32'h0);
    w_start <= 1'b0;
    tick(T_OFF + 16);
    w_start <= 1'b1;
    wait_cont(1'b1, 10);
    // Coast stop while running
    tick(10);
    w_coast <= 1'b0;
    wait_cont(1'b0, 8);
    tick(4);
    cmp(32'({contactor_out, drive_run, speed_demand}), 32'h0);
    results();
  end
endmodule
